// *** shared/ddrbs_pkg.sv ***
// Shared constants and types of the two-word burst DDR SRAM interface
package ddrbs_pkg;

  // ==========================================================================
  // Geometry defaults
  // ==========================================================================
  localparam int DDRBS_DATA_W = 36;
  localparam int DDRBS_ADDR_W = 20;
  localparam int DDRBS_NBW    = 4;
  localparam int DDRBS_BURST  = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  // Loop mode assumed on (1.5-cycle latency) until the strap settles
  localparam logic DDRBS_LOOP_RST  = 1'b1;
  localparam logic DDRBS_RESET_RST = 1'b1;
  localparam logic DDRBS_IDLE      = 1'b0;

  // ==========================================================================
  // Half-cycle phase of the link: K edge carries read slot, K# edge write slot
  // ==========================================================================
  typedef enum logic [1:0] {
    DDRBS_PH_K  = 2'b01,
    DDRBS_PH_KN = 2'b10
  } ddrbs_phase_t;

endpackage : ddrbs_pkg

// *** hdl/ddrbs_sram_top.sv ***
// Two-word burst DDR SRAM interface: device-side logic with its storage array
//
// Notes on behaviour
// (R1) Separate read data outputs and write data inputs; no bus turnaround.
// (R2) Read and write slots are processed independently and may overlap.
// (R3) Every access moves exactly two words per address.
// (R4) Address bus carries read address on K edge, write address on K# edge.
// (R5) Two words of one address move in sequence; word width is a parameter.
// (R6) One word per rising edge of K and of K#, two per cycle.
// (R7) Only rising edges are used; K# is a second rising-edge reference.
// (R8) Loop enable high: first read word 1.5 cycles after address capture.
// (R9) Loop enable low: first read word 1 cycle after address capture.
// (R10) Address, selects, byte controls and write data pass input registers.
// (R11) Read data leaves output registers; single clock domain uses K pair.
// (R12) Complementary echo strobes launched with, and aligned to, read data.
// (R13) Each port has its own select; unselected port slots are ignored.
// (R14) Array write is self-timed after the second word; no write pulse.
// (R15) A read returns the newest data, including a write still in flight.
// (R16) Controller keeps the interface clock at or below its rated maximum.
// (R17) Selects are active low; idle read outputs when the read select is off.
`timescale 1ns/10ps

// ============================================================================
// Three-stage synchroniser: a change counts once stages two and three agree
// ============================================================================
module ddrbs_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_q;

  always_comb begin
    next_stage = {stage[1:0], d};
    next_q     = (stage[1] == stage[2]) ? stage[2] : q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage <= {3{RST_VAL}};
      q     <= RST_VAL;
    end else begin
      stage <= next_stage;
      q     <= next_q;
    end
  end
endmodule : ddrbs_sync3

// ============================================================================
// Top level
// ============================================================================
module ddrbs_sram_top
  import ddrbs_pkg::*;
#(
  parameter int DATA_W = DDRBS_DATA_W,
  parameter int ADDR_W = DDRBS_ADDR_W,
  parameter int NBW    = DDRBS_NBW
) (
  input  wire logic              REF_CLK,
  input  wire logic              SYS_RST,
  input  wire logic              LOOP_ENABLE_PIN,
  input  wire logic              LINK_CLK,
  input  wire logic [ADDR_W-1:0] ADDRESS,
  input  wire logic              READ_PORT_SELECT_N,
  input  wire logic              WRITE_PORT_SELECT_N,
  input  wire logic [NBW-1:0]    BYTE_WRITE_N,
  input  wire logic [DATA_W-1:0] WRITE_DATA,
  output logic      [DATA_W-1:0] READ_DATA,
  output logic                   READ_VALID,
  output logic                   ECHO_STROBE,
  output logic                   ECHO_STROBE_N
);
  localparam int LANE_W  = DATA_W / NBW;
  localparam int PAIR_W  = DDRBS_BURST * DATA_W;
  localparam int DEPTH   = 2 ** ADDR_W;

  // ==========================================================================
  // Reference domain: strap sampling
  // ==========================================================================
  logic loop_mode_ref;
  logic loop_mode;
  logic link_rst;

  ddrbs_sync3 #(.RST_VAL(DDRBS_LOOP_RST)) u_strap_sync (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .d   (LOOP_ENABLE_PIN),
    .q   (loop_mode_ref)
  );

  // ==========================================================================
  // Crossings into the link domain
  // ==========================================================================
  // Reset synchroniser has no reset of its own; hold SYS_RST long enough
  ddrbs_sync3 #(.RST_VAL(DDRBS_RESET_RST)) u_rst_sync (
    .clk (LINK_CLK),
    .rst (1'b0),
    .d   (SYS_RST),
    .q   (link_rst)
  );

  ddrbs_sync3 #(.RST_VAL(DDRBS_LOOP_RST)) u_mode_sync (
    .clk (LINK_CLK),
    .rst (link_rst),
    .d   (loop_mode_ref),
    .q   (loop_mode)
  );

  // ==========================================================================
  // Link domain state
  // ==========================================================================
  ddrbs_phase_t      phase,    next_phase;
  ddrbs_phase_t      in_phase, next_in_phase;
  logic [ADDR_W-1:0] in_addr,  next_in_addr;
  logic              in_rsel,  next_in_rsel;
  logic              in_wsel,  next_in_wsel;
  logic [NBW-1:0]    in_bw_n,  next_in_bw_n;
  logic [DATA_W-1:0] in_d,     next_in_d;
  logic [ADDR_W-1:0] wr_addr,  next_wr_addr;
  logic [DATA_W-1:0] wr_w0,    next_wr_w0;
  logic [NBW-1:0]    wr_bw0_n, next_wr_bw0_n;
  logic              wr_pend,  next_wr_pend;
  logic [PAIR_W-1:0] rs1, rs2, rs3;
  logic [PAIR_W-1:0] next_rs1, next_rs2, next_rs3;
  logic              v1, v2, v3;
  logic              next_v1, next_v2, next_v3;
  logic [DATA_W-1:0] next_read_data;
  logic              next_read_valid;
  logic              next_echo;
  logic [PAIR_W-1:0] mem [DEPTH];
  logic              commit;
  logic [PAIR_W-1:0] mem_old;
  logic [PAIR_W-1:0] mem_wdata;
  logic [PAIR_W-1:0] rd_data;
  logic              slot_k;
  logic              first_word;
  logic              second_word;

  // Lanes whose byte control is low take the new data
  function automatic logic [DATA_W-1:0] merge_lanes(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [NBW-1:0]    bw_n
  );
    logic [DATA_W-1:0] result;
    result = old_word;
    for (int i = 0; i < NBW; i++) begin
      if (!bw_n[i]) begin
        result[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    return result;
  endfunction : merge_lanes

  // ==========================================================================
  // Input registers
  // ==========================================================================
  always_comb begin
    next_phase    = (phase == DDRBS_PH_K) ? DDRBS_PH_KN : DDRBS_PH_K;  // [R6] [R7]
    next_in_phase = phase;
    next_in_addr  = ADDRESS;                                              // [R10]
    next_in_bw_n  = BYTE_WRITE_N;
    next_in_d     = WRITE_DATA;
    // Each select counts only on its own slot edge
    next_in_rsel  = (phase == DDRBS_PH_K)  && !READ_PORT_SELECT_N;       // [R4] [R13] [R17]
    next_in_wsel  = (phase == DDRBS_PH_KN) && !WRITE_PORT_SELECT_N;      // [R4] [R13] [R17]
  end

  // ==========================================================================
  // Write path and coherent read lookup
  // ==========================================================================
  always_comb begin
    slot_k        = (in_phase == DDRBS_PH_K);
    next_wr_addr  = wr_addr;
    next_wr_w0    = wr_w0;
    next_wr_bw0_n = wr_bw0_n;
    next_wr_pend  = wr_pend;
    if (!slot_k && in_wsel) begin                                         // [R2] [R3]
      next_wr_addr  = in_addr;
      next_wr_w0    = in_d;
      next_wr_bw0_n = in_bw_n;
      next_wr_pend  = 1'b1;
    end else if (slot_k) begin
      next_wr_pend  = 1'b0;
    end
    // Second word has arrived: write both words without any external strobe
    commit    = slot_k && wr_pend;                                        // [R14] [R5]
    mem_old   = mem[wr_addr];
    mem_wdata = {merge_lanes(mem_old[DATA_W +: DATA_W], in_d, in_bw_n),
                 merge_lanes(mem_old[0 +: DATA_W], wr_w0, wr_bw0_n)};
    // Forward the write committed on this very edge
    rd_data   = (commit && (wr_addr == in_addr)) ? mem_wdata : mem[in_addr];  // [R15]
  end

  // ==========================================================================
  // Read pipeline and output registers
  // ==========================================================================
  always_comb begin
    next_v1  = slot_k && in_rsel;                                         // [R2] [R13]
    next_rs1 = next_v1 ? rd_data : rs1;
    next_v2  = v1;
    next_rs2 = rs1;
    next_v3  = v2;
    next_rs3 = rs2;
    // Extra half cycle of delay in loop mode; mode changes during a burst may garble it
    if (loop_mode) begin
      first_word  = v2;                                                   // [R8]
      second_word = v3;
    end else begin
      first_word  = v1;                                                   // [R9]
      second_word = v2;
    end
    if (first_word) begin
      next_read_data = loop_mode ? rs2[0 +: DATA_W] : rs1[0 +: DATA_W];   // [R5] [R3]
    end else if (second_word) begin
      next_read_data = loop_mode ? rs3[DATA_W +: DATA_W] : rs2[DATA_W +: DATA_W];
    end else begin
      next_read_data = '0;                                                // [R17]
    end
    next_read_valid = first_word || second_word;
    next_echo       = (phase == DDRBS_PH_K);                              // [R12]
  end

  // ==========================================================================
  // Link domain registers
  // ==========================================================================
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      phase         <= DDRBS_PH_K;
      in_phase      <= DDRBS_PH_K;
      in_addr       <= '0;
      in_rsel       <= DDRBS_IDLE;
      in_wsel       <= DDRBS_IDLE;
      in_bw_n       <= '1;
      in_d          <= '0;
      wr_addr       <= '0;
      wr_w0         <= '0;
      wr_bw0_n      <= '1;
      wr_pend       <= DDRBS_IDLE;
      rs1           <= '0;
      rs2           <= '0;
      rs3           <= '0;
      v1            <= DDRBS_IDLE;
      v2            <= DDRBS_IDLE;
      v3            <= DDRBS_IDLE;
      READ_DATA     <= '0;
      READ_VALID    <= DDRBS_IDLE;
      ECHO_STROBE   <= DDRBS_IDLE;
      ECHO_STROBE_N <= !DDRBS_IDLE;
    end else begin
      phase         <= next_phase;
      in_phase      <= next_in_phase;                                     // [R10]
      in_addr       <= next_in_addr;
      in_rsel       <= next_in_rsel;
      in_wsel       <= next_in_wsel;
      in_bw_n       <= next_in_bw_n;
      in_d          <= next_in_d;
      wr_addr       <= next_wr_addr;
      wr_w0         <= next_wr_w0;
      wr_bw0_n      <= next_wr_bw0_n;
      wr_pend       <= next_wr_pend;
      rs1           <= next_rs1;
      rs2           <= next_rs2;
      rs3           <= next_rs3;
      v1            <= next_v1;
      v2            <= next_v2;
      v3            <= next_v3;
      READ_DATA     <= next_read_data;                                    // [R1] [R11]
      READ_VALID    <= next_read_valid;
      ECHO_STROBE   <= next_echo;                                         // [R12]
      ECHO_STROBE_N <= !next_echo;
    end
  end

  // Array holds no reset; contents are undefined until written
  always_ff @(posedge LINK_CLK) begin
    if (commit) begin
      mem[wr_addr] <= mem_wdata;                                          // [R14]
    end
  end

endmodule : ddrbs_sram_top

// *** sim/ddrbs_checker.sv ***
// Concurrent checks on the link-side ports of the burst SRAM
`timescale 1ns/10ps
module ddrbs_checker #(
  parameter int DATA_W = 16
) (
  input wire logic              LINK_CLK,
  input wire logic              SYS_RST,
  input wire logic              LOOP_ENABLE_PIN,
  input wire logic              READ_PORT_SELECT_N,
  input wire logic [DATA_W-1:0] READ_DATA,
  input wire logic              READ_VALID,
  input wire logic              ECHO_STROBE,
  input wire logic              ECHO_STROBE_N
);
  logic       strap;
  logic [4:0] age;
  logic [3:0] run;
  // Strap crosses two domains; latency is judged only once it is old
  always_ff @(posedge LINK_CLK) begin
    strap <= LOOP_ENABLE_PIN;
    age   <= (SYS_RST || strap != LOOP_ENABLE_PIN) ? 5'h00 : age + {4'h0, age != 5'h1F};
    run   <= (SYS_RST || !READ_VALID) ? 4'h0 : run + 4'h1;
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge LINK_CLK); endclocking
  default disable iff (SYS_RST);
  property p_echo_pair; ECHO_STROBE_N == !ECHO_STROBE; endproperty
  a_echo_pair: assert property (p_echo_pair) else $error("echo pair not complementary");
  property p_echo_high; ECHO_STROBE |=> !ECHO_STROBE; endproperty
  a_echo_high: assert property (p_echo_high) else $error("echo high for two edges");
  property p_echo_low; $fell(ECHO_STROBE) |=> ECHO_STROBE; endproperty
  a_echo_low: assert property (p_echo_low) else $error("echo low for two edges");
  property p_idle_zero; !READ_VALID |-> READ_DATA == '0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle read data not zero");
  property p_lat_legacy;
    (!READ_PORT_SELECT_N && !ECHO_STROBE && age == 5'h1F && !LOOP_ENABLE_PIN) |-> ##3 READ_VALID ##1 READ_VALID;
  endproperty
  a_lat_legacy: assert property (p_lat_legacy) else $error("legacy read latency wrong");
  property p_lat_loop;
    (!READ_PORT_SELECT_N && !ECHO_STROBE && age == 5'h1F && LOOP_ENABLE_PIN) |-> ##4 READ_VALID ##1 READ_VALID;
  endproperty
  a_lat_loop: assert property (p_lat_loop) else $error("loop read latency wrong");
  property p_no_stray;
    $rose(READ_VALID) |-> (!$past(READ_PORT_SELECT_N, 3) && !$past(ECHO_STROBE, 3)) ||
                          (!$past(READ_PORT_SELECT_N, 4) && !$past(ECHO_STROBE, 4));
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("read words without a read");
  property p_even_run; $fell(READ_VALID) |-> !run[0]; endproperty
  a_even_run: assert property (p_even_run) else $error("read burst not two words");
endmodule : ddrbs_checker

bind ddrbs_sram_top ddrbs_checker #(.DATA_W(DATA_W)) u_chk (
  .LINK_CLK           (LINK_CLK),
  .SYS_RST            (SYS_RST),
  .LOOP_ENABLE_PIN    (LOOP_ENABLE_PIN),
  .READ_PORT_SELECT_N (READ_PORT_SELECT_N),
  .READ_DATA          (READ_DATA),
  .READ_VALID         (READ_VALID),
  .ECHO_STROBE        (ECHO_STROBE),
  .ECHO_STROBE_N      (ECHO_STROBE_N)
);

// *** sim/ddrbs_ctl_model.sv ***
// Behavioural memory controller on the far side of the burst SRAM link
`timescale 1ns/10ps
module ddrbs_ctl_model #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 6,
  parameter int NBW    = 2
) (
  input  wire logic              link_clk,
  input  wire logic              echo,
  input  wire logic              rd_valid,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic      [ADDR_W-1:0] addr,
  output logic                   rsel_n,
  output logic                   wsel_n,
  output logic      [NBW-1:0]    bw_n,
  output logic      [DATA_W-1:0] wdata
);
  logic [DATA_W-1:0] rq[$];
  logic [DATA_W-1:0] pend_d;
  logic [NBW-1:0]    pend_b;
  initial begin
    addr   = '0;
    rsel_n = 1'b1;
    wsel_n = 1'b1;
    bw_n   = '1;
    wdata  = '0;
    pend_d = '1;
    pend_b = '1;
  end
  // One K slot then one K# slot; word1 of a write rides the next K slot
  task automatic pair(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr, input logic [ADDR_W-1:0] wa,
                      input logic [DATA_W-1:0] d0, d1, input logic [NBW-1:0] b0, b1, input logic bad);
    @(negedge link_clk);
    while (echo !== 1'b0) @(negedge link_clk);
    rsel_n <= !rd;
    wsel_n <= !bad;
    addr   <= (rd || bad) ? ra : ~addr;
    wdata  <= pend_d;
    bw_n   <= pend_b;
    @(negedge link_clk);
    rsel_n <= !bad;
    wsel_n <= !wr;
    addr   <= wr ? wa : ~ra;
    // Unused address and data lines carry noise, never a stale value
    wdata  <= wr ? d0 : ~pend_d;
    bw_n   <= b0;
    pend_d <= wr ? d1 : ~d1;
    pend_b <= b1;
  endtask : pair
  always @(negedge link_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
endmodule : ddrbs_ctl_model

// *** sim/ddr_burst2_sram_interface_test.sv ***
// Self-checking bench for the two-word burst SRAM link
`timescale 1ns/10ps
module ddr_burst2_sram_interface_test;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int NBW    = 2;
  typedef struct packed {
    logic [5:0] a; logic [15:0] d0; logic [15:0] d1; logic [1:0] b0; logic [1:0] b1; logic [15:0] e0; logic [15:0] e1;
  } ddrbs_row_t;
  // Address, words, lane enables, expected words
  ddrbs_row_t rows [3] = '{'{6'h05, 16'h1234, 16'hABCD, 2'h0, 2'h0, 16'h1234, 16'hABCD},
                          '{6'h05, 16'hFFFF, 16'h0000, 2'h1, 2'h2, 16'hFF34, 16'hAB00},
                          '{6'h3F, 16'h5A5A, 16'hA5A5, 2'h0, 2'h0, 16'h5A5A, 16'hA5A5}};
  logic        ref_clk  = 1'b0;
  logic        link_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        loop_pin = 1'b1;
  logic [5:0]  address;
  logic        rsel_n, wsel_n, rd_valid, echo, echo_n;
  logic [1:0]  bw_n;
  logic [15:0] wdata, rd_data;
  int          err_total  = 0;
  int          n_compared = 0;
  initial forever #50 ref_clk = ~ref_clk;
  // Link runs far below the rated maximum and off the reference phase
  initial begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  ddrbs_sram_top #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .NBW(NBW)) DUT (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
    .LOOP_ENABLE_PIN(loop_pin), .LINK_CLK(link_clk), .ADDRESS(address), .READ_PORT_SELECT_N(rsel_n),
    .WRITE_PORT_SELECT_N(wsel_n), .BYTE_WRITE_N(bw_n), .WRITE_DATA(wdata), .READ_DATA(rd_data),
    .READ_VALID(rd_valid), .ECHO_STROBE(echo), .ECHO_STROBE_N(echo_n));
  ddrbs_ctl_model #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .NBW(NBW)) u_ctl (.link_clk(link_clk), .echo(echo),
    .rd_valid(rd_valid), .rd_data(rd_data), .addr(address), .rsel_n(rsel_n), .wsel_n(wsel_n),
    .bw_n(bw_n), .wdata(wdata));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic take(input logic [15:0] e0, input logic [15:0] e1);
    int n;
    n = 0;
    while (u_ctl.rq.size() < 2 && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    chk("word0", e0, (u_ctl.rq.size() > 0) ? u_ctl.rq.pop_front() : 16'hXXXX);
    chk("word1", e1, (u_ctl.rq.size() > 0) ? u_ctl.rq.pop_front() : 16'hXXXX);
  endtask : take
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    #300000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    sys_rst <= 1'b0;
    repeat (10) @(negedge link_clk);
    // Read issued in the same K slot that carries word1 of the write
    foreach (rows[i]) begin
      u_ctl.pair(1'b0, 6'h00, 1'b1, rows[i].a, rows[i].d0, rows[i].d1, rows[i].b0, rows[i].b1, 1'b0);
      u_ctl.pair(1'b1, rows[i].a, 1'b0, 6'h00, 16'h0, 16'h0, 2'h0, 2'h0, 1'b0);
      take(rows[i].e0, rows[i].e1);
      $display("row %0d done", i);
    end
    u_ctl.pair(1'b0, 6'h3F, 1'b0, 6'h00, 16'h0, 16'h0, 2'h0, 2'h0, 1'b1);
    u_ctl.pair(1'b0, 6'h00, 1'b0, 6'h00, 16'h0, 16'h0, 2'h0, 2'h0, 1'b0);
    repeat (8) @(negedge link_clk);
    chk("stray words", 16'h0000, 16'(u_ctl.rq.size()));
    u_ctl.pair(1'b1, 6'h3F, 1'b0, 6'h00, 16'h0, 16'h0, 2'h0, 2'h0, 1'b0);
    take(16'h5A5A, 16'hA5A5);
    $display("wrong-slot selects done");
    @(negedge ref_clk) loop_pin <= 1'b0;
    repeat (40) @(negedge link_clk);
    u_ctl.pair(1'b1, 6'h05, 1'b1, 6'h09, 16'h1111, 16'h2222, 2'h0, 2'h0, 1'b0);
    u_ctl.pair(1'b1, 6'h09, 1'b0, 6'h00, 16'h0, 16'h0, 2'h0, 2'h0, 1'b0);
    take(16'hFF34, 16'hAB00);
    take(16'h1111, 16'h2222);
    $display("legacy concurrent done");
    @(negedge ref_clk) sys_rst <= 1'b1;
    repeat (12) @(negedge ref_clk);
    chk("reset flags", 16'h0002, {13'h0, echo, echo_n, rd_valid});
    chk("reset data", 16'h0000, rd_data);
    sys_rst <= 1'b0;
    // Array keeps its contents across reset; link restarts on a read slot
    repeat (16) @(negedge link_clk);
    u_ctl.pair(1'b1, 6'h05, 1'b0, 6'h00, 16'h0, 16'h0, 2'h0, 2'h0, 1'b0);
    take(16'hFF34, 16'hAB00);
    $display("second reset done");
    summarize();
  end
endmodule : ddr_burst2_sram_interface_test
